// ### design/incdec_exec.v
// Execution unit for increment, decrement, skip, branch and OR instructions
`timescale 1ns/1ns
`default_nettype none
`include "incdec_consts.vh"

module incdec_exec #(
    parameter DATA_W = 8,
    parameter PC_W = 13
) (
    // Clock and reset
    input wire i_sys_clk,
    input wire i_nrst,
    // Instruction issue
    input wire i_valid,
    input wire [13:0] i_instr,
    // Operands from the core
    input wire [DATA_W-1:0] i_w,
    input wire [DATA_W-1:0] i_file_data,
    input wire [DATA_W-1:0] i_page_latch,
    // Results
    output wire o_w_we,
    output wire [DATA_W-1:0] o_w_data,
    output wire o_file_we,
    output wire [6:0] o_file_addr,
    output wire [DATA_W-1:0] o_file_data,
    output wire o_z_we,
    output wire o_z,
    // Control flow
    output wire o_pc_load,
    output wire [PC_W-1:0] o_pc,
    output wire o_flush,
    output wire o_busy
);

    // ==========================================================
    // Reset synchroniser
    reg rst_meta_q;
    reg rst_n_q;
    always @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ==========================================================
    // Decode
    function is_zero;
        input [DATA_W-1:0] v;
        begin
            is_zero = (v == {DATA_W{1'b0}});
        end
    endfunction

    wire [5:0] op6 = i_instr[`OPC_HI:`OPC6_LO];
    wire [2:0] op3 = i_instr[`OPC_HI:`OPC3_LO];
    wire dest_f = i_instr[`DEST_BIT];
    wire [6:0] faddr = i_instr[`FADDR_HI:0];
    wire [7:0] lit8 = i_instr[`LIT8_HI:0];
    wire [10:0] lit11 = i_instr[`LIT11_HI:0];
    // Two-cycle sequencer states
    localparam ST_ISSUE = 1'b0;
    localparam ST_SECOND = 1'b1;
    reg state_q;
    reg state_d;
    // Second cycle of a two-cycle instruction executes nothing
    wire issue = i_valid && (state_q == ST_ISSUE);

    reg [DATA_W-1:0] res;
    reg wr_res;
    reg dst_f;
    reg z_upd;
    reg skip;
    reg branch;
    always @*
    begin
        res = `ZERO8;
        wr_res = 1'b0;
        dst_f = dest_f;
        z_upd = 1'b0;
        skip = 1'b0;
        branch = 1'b0;
        if (issue)
        begin
            if (op3 == `OP3_BRANCH)
            begin
                branch = 1'b1;
            end
            else
            begin
                case (op6)
                    `OP_DEC_SKIP:
                    begin
                        res = i_file_data - `ONE8;
                        wr_res = 1'b1;
                        skip = is_zero(res);
                    end
                    `OP_INC_SKIP:
                    begin
                        res = i_file_data + `ONE8;
                        wr_res = 1'b1;
                        skip = is_zero(res);
                    end
                    `OP_INC_FILE:
                    begin
                        res = i_file_data + `ONE8;
                        wr_res = 1'b1;
                        z_upd = 1'b1;
                    end
                    `OP_OR_FILE:
                    begin
                        res = i_w | i_file_data;
                        wr_res = 1'b1;
                        z_upd = 1'b1;
                    end
                    `OP_OR_LIT:
                    begin
                        res = i_w | lit8;
                        wr_res = 1'b1;
                        dst_f = 1'b0;
                        z_upd = 1'b1;
                    end
                    default:
                    begin
                        wr_res = 1'b0;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Two-cycle sequencer
    always @*
    begin
        state_d = ST_ISSUE;
        case (state_q)
            ST_ISSUE:
            begin
                if (skip || branch)
                begin
                    state_d = ST_SECOND;
                end
            end
            ST_SECOND:
            begin
                state_d = ST_ISSUE;
            end
            default:
            begin
                state_d = ST_ISSUE;
            end
        endcase
    end

    always @(posedge i_sys_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q <= ST_ISSUE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Result registers
    reg w_we_q;
    reg [DATA_W-1:0] w_data_q;
    reg file_we_q;
    reg [6:0] file_addr_q;
    reg [DATA_W-1:0] file_data_q;
    reg z_we_q;
    reg z_q;
    reg pc_load_q;
    reg [PC_W-1:0] pc_q;
    reg flush_q;
    always @(posedge i_sys_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            w_we_q <= 1'b0;
            w_data_q <= `ZERO8;
            file_we_q <= 1'b0;
            file_addr_q <= `ZERO7;
            file_data_q <= `ZERO8;
            z_we_q <= 1'b0;
            z_q <= 1'b0;
            pc_load_q <= 1'b0;
            pc_q <= `ZERO13;
            flush_q <= 1'b0;
        end
        else
        begin
            w_we_q <= wr_res && !dst_f;
            w_data_q <= res;
            file_we_q <= wr_res && dst_f;
            file_addr_q <= faddr;
            file_data_q <= res;
            z_we_q <= z_upd;
            z_q <= is_zero(res);
            pc_load_q <= branch;
            if (branch)
            begin
                pc_q <= {i_page_latch[`PAGE_HI:`PAGE_LO], lit11};
            end
            flush_q <= skip || branch;
        end
    end

    // ==========================================================
    // Outputs straight from the registers
    assign o_w_we = w_we_q;
    assign o_w_data = w_data_q;
    assign o_file_we = file_we_q;
    assign o_file_addr = file_addr_q;
    assign o_file_data = file_data_q;
    assign o_z_we = z_we_q;
    assign o_z = z_q;
    assign o_pc_load = pc_load_q;
    assign o_pc = pc_q;
    assign o_flush = flush_q;
    assign o_busy = state_q;

endmodule // incdec_exec
`default_nettype wire

// ### design/incdec_consts.vh
// Constants for the increment, decrement, branch and OR execution block
`ifndef INCDEC_CONSTS_VH
`define INCDEC_CONSTS_VH

// Instruction field positions in the 14-bit instruction word
`define OPC_HI 13
`define OPC6_LO 8
`define OPC3_LO 11
`define DEST_BIT 7
`define FADDR_HI 6
`define LIT8_HI 7
`define LIT11_HI 10

// Six-bit opcodes of the byte-oriented file group
`define OP_DEC_SKIP 6'h0B
`define OP_INC_SKIP 6'h0F
`define OP_INC_FILE 6'h0A
`define OP_OR_FILE 6'h04
// Literal opcodes
`define OP_OR_LIT 6'h38
`define OP3_BRANCH 3'h5

// Page latch bits that feed the upper program counter
`define PAGE_HI 4
`define PAGE_LO 3

// Reset values and the increment/decrement step
`define ZERO8 8'h00
`define ZERO7 7'h00
`define ZERO13 13'h0000
`define ONE8 8'h01

`endif

// ### dv/incdec_exec_asserts.sv
// Checker for the increment, decrement, branch and OR unit
`timescale 1ns/1ns
`default_nettype none
module incdec_exec_asserts (
    input wire logic i_sys_clk, i_nrst, i_valid, o_w_we, o_file_we, o_z_we, o_z,
    input wire logic o_pc_load, o_flush, o_busy,
    input wire logic [13:0] i_instr,
    input wire logic [7:0] i_w, i_file_data, i_page_latch, o_w_data, o_file_data,
    input wire logic [6:0] o_file_addr,
    input wire logic [12:0] o_pc
);
    // ==========
    // Taken requests
    wire tk = i_valid & ~o_busy;
    wire [5:0] op = i_instr[13:8];
    wire dc = tk && op == 6'h0B && i_instr[7];
    wire dz = tk && op == 6'h0B && i_file_data == 8'h01;
    wire ic = tk && op == 6'h0A && !i_instr[7];
    wire is = tk && op == 6'h0F;
    wire br = tk && i_instr[13:11] == 3'h5;
    wire ol = tk && op == 6'h38;
    wire of = tk && op == 6'h04 && i_instr[7];
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    a_dec_result: assert property ($past(dc) |-> o_file_we && !o_z_we
        && o_file_data == $past(i_file_data) - 8'h01) else $error("dec result");
    a_dec_skip: assert property ($past(dz) |-> o_flush && o_busy ##1 !o_busy)
        else $error("dec skip");
    a_inc_result: assert property ($past(ic) |-> o_w_we && o_z_we
        && o_w_data == $past(i_file_data) + 8'h01) else $error("inc result");
    a_incs_skip: assert property ($past(is) |-> !o_z_we
        && o_flush == ($past(i_file_data) == 8'hFF)) else $error("inc skip");
    a_branch_pc: assert property ($past(br) |-> o_pc_load && o_busy && !o_z_we
        && o_pc == {$past(i_page_latch[4:3]), $past(i_instr[10:0])} ##1 !o_busy)
        else $error("branch");
    a_or_lit: assert property ($past(ol) |-> o_w_we && o_z_we
        && o_w_data == ($past(i_w) | $past(i_instr[7:0]))) else $error("or literal");
    a_or_file: assert property ($past(of) |-> o_file_we && o_z_we
        && o_file_data == ($past(i_w) | $past(i_file_data))) else $error("or file");
    a_zero_flag: assert property (o_z_we |->
        o_z == ((o_w_we ? o_w_data : o_file_data) == 8'h00)) else $error("zero flag");
    a_busy_drop: assert property ($past(o_busy) |-> !o_w_we && !o_file_we
        && !o_z_we && !o_pc_load && !o_flush && !o_busy) else $error("busy cycle");
endmodule // incdec_exec_asserts
bind incdec_exec incdec_exec_asserts incdec_exec_asserts_i (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_valid(i_valid), .i_instr(i_instr),
    .i_w(i_w), .i_file_data(i_file_data), .i_page_latch(i_page_latch),
    .o_w_we(o_w_we), .o_w_data(o_w_data), .o_file_we(o_file_we),
    .o_file_addr(o_file_addr), .o_file_data(o_file_data), .o_z_we(o_z_we), .o_z(o_z),
    .o_pc_load(o_pc_load), .o_pc(o_pc), .o_flush(o_flush), .o_busy(o_busy)
);
`default_nettype wire

// ### dv/incdec_exec_tb.sv
// Self-checking bench for the increment, decrement, branch and OR unit
`timescale 1ns/1ns
`default_nettype none
module incdec_exec_tb;
    // ==========
    // Stimulus and design
    logic i_sys_clk = 1'b0, i_nrst = 1'b0, i_valid = 1'b0;
    logic [13:0] i_instr = 14'h0000;
    logic [7:0] i_w = 8'h00, i_file_data = 8'h00, i_page_latch = 8'h00;
    wire o_w_we, o_file_we, o_z_we, o_z, o_pc_load, o_flush, o_busy;
    wire [7:0] o_w_data, o_file_data;
    wire [6:0] o_file_addr;
    wire [12:0] o_pc;
    int n_fail = 0, n_compared = 0, cyc = 0;
    always #10 i_sys_clk = ~i_sys_clk;
    incdec_exec incdec_exec_i (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_valid(i_valid),
        .i_instr(i_instr),
        .i_w(i_w),
        .i_file_data(i_file_data),
        .i_page_latch(i_page_latch),
        .o_w_we(o_w_we),
        .o_w_data(o_w_data),
        .o_file_we(o_file_we),
        .o_file_addr(o_file_addr),
        .o_file_data(o_file_data),
        .o_z_we(o_z_we),
        .o_z(o_z),
        .o_pc_load(o_pc_load),
        .o_pc(o_pc),
        .o_flush(o_flush),
        .o_busy(o_busy)
    );
    task close_out;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge i_sys_clk)
    begin
        cyc++;
        if (cyc == 500)
        begin
            n_fail++;
            close_out();
        end
    end
    task chk(input string nm, input logic [12:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Holds one request for one edge
    task iss(input logic [13:0] ins, input logic [7:0] w, f, pg);
        i_valid = 1'b1;
        i_instr = ins;
        i_w = w;
        i_file_data = f;
        i_page_latch = pg;
        @(negedge i_sys_clk);
    endtask
    task idle;
        i_valid = 1'b0;
        @(negedge i_sys_clk);
    endtask
    task t_dec;
        iss(14'h0BFF, 8'h00, 8'h01, 8'h00);
        chk("fd", 0, o_file_data);
        chk("fl", 1, o_flush);
        chk("fa", 13'h7F, o_file_addr);
        chk("fw", 1, o_file_we);
        idle();
        chk("bz", 0, o_busy);
        iss(14'h0B05, 8'h00, 8'h00, 8'h00);
        chk("wd", 13'hFF, o_w_data);
        chk("fl", 0, o_flush);
        $display("dec test done");
    endtask
    task t_inc;
        iss(14'h0A00, 8'h00, 8'hFF, 8'h00);
        chk("wd", 0, o_w_data);
        chk("z", 1, o_z);
        iss(14'h0F80, 8'h00, 8'hFF, 8'h00);
        chk("fl", 1, o_flush);
        chk("zw", 0, o_z_we);
        idle();
        iss(14'h0A85, 8'h00, 8'h7F, 8'h00);
        chk("fw", 1, o_file_we);
        chk("fd", 13'h80, o_file_data);
        chk("z", 0, o_z);
        idle();
        $display("inc test done");
    endtask
    task t_br;
        iss(14'h2FFF, 8'h00, 8'h00, 8'h18);
        chk("pc", 13'h1FFF, o_pc);
        chk("bz", 1, o_busy);
        chk("pl", 1, o_pc_load);
        iss(14'h3801, 8'h00, 8'h00, 8'h00);
        chk("ww", 0, o_w_we);
        iss(14'h2A55, 8'h00, 8'h00, 8'h08);
        chk("pc", 13'h0A55, o_pc);
        idle();
        $display("branch test done");
    endtask
    task t_or;
        iss(14'h3800, 8'h00, 8'h00, 8'h00);
        chk("z", 1, o_z);
        iss(14'h0481, 8'hA0, 8'h05, 8'h00);
        chk("ww", 0, o_w_we);
        chk("fw", 1, o_file_we);
        chk("fd", 13'hA5, o_file_data);
        chk("z", 0, o_z);
        iss(14'h3812, 8'h21, 8'h00, 8'h00);
        chk("ww", 1, o_w_we);
        chk("wd", 13'h33, o_w_data);
        iss(14'h0401, 8'h0F, 8'hF0, 8'h00);
        chk("ww", 1, o_w_we);
        chk("wd", 13'hFF, o_w_data);
        idle();
        $display("or test done");
    endtask
    initial
    begin
        repeat (12) @(negedge i_sys_clk);
        i_nrst = 1'b1;
        repeat (3) @(negedge i_sys_clk);
        t_dec();
        t_inc();
        t_br();
        t_or();
        close_out();
    end
endmodule // incdec_exec_tb
`default_nettype wire
